/* common/tai_defs.vh */
/*
 * register map, field positions and reset values of the timer array
 * with its interval channel 3; assumes a 32-bit apb slave, word offsets
 */
`ifndef TAI_DEFS_VH
`define TAI_DEFS_VH

// register byte offsets
`define TAI_A_UNIT_RST 8'h00
`define TAI_A_CLK_GATE 8'h04
`define TAI_A_PRESCALE 8'h08
`define TAI_A_STOP 8'h0c
`define TAI_A_START 8'h10
`define TAI_A_RUN 8'h14
`define TAI_A_IRQ_MASK 8'h18
`define TAI_A_IRQ_REQ 8'h1c
`define TAI_A_IRQ_PRIO 8'h20
`define TAI_A_CH3_MODE 8'h24
`define TAI_A_CH3_DATA 8'h28
`define TAI_A_OUT_MODE 8'h2c
`define TAI_A_OUT_POL 8'h30
`define TAI_A_OUT_VAL 8'h34
`define TAI_A_OUT_GATE 8'h38
`define TAI_A_CH3_COUNT 8'h3c

// channel 3 bit in the run, output and stop/start registers
`define TAI_CH3 3
// channel 3 bit in the interrupt mask, request and priority bytes
`define TAI_IRQ3 5

// prescaler fields
`define TAI_PS0_HI 3
`define TAI_PS0_LO 0
`define TAI_PS1_HI 7
`define TAI_PS1_LO 4
`define TAI_PS2_HI 9
`define TAI_PS2_LO 8
`define TAI_PS3_HI 13
`define TAI_PS3_LO 12

// channel 3 mode fields
`define TAI_M_CKS_HI 15
`define TAI_M_CKS_LO 14
`define TAI_M_CCS 12
`define TAI_M_SPLIT 11
`define TAI_M_STS_HI 10
`define TAI_M_STS_LO 8
`define TAI_M_CIS_HI 7
`define TAI_M_CIS_LO 6
`define TAI_M_MD_HI 3
`define TAI_M_MD_LO 1
`define TAI_M_MD0 0

// codes
`define TAI_MD_INTERVAL 3'h0
`define TAI_CKS_CK0 2'h0
`define TAI_CKS_CK2 2'h1
`define TAI_CKS_CK1 2'h2
`define TAI_CIS_FALL 2'h0
`define TAI_CIS_RISE 2'h1

// reset values
`define TAI_RST_W16 16'h0000
`define TAI_RST_W8 8'h00

`endif

/* hw/tai_timer_array.v */
/*
 * timer array with channel 3 as a down-counting interval timer,
 * unit reset and clock gate, prescaler, stop/start triggers,
 * channel 3 interrupt mask/flag/priority and timer output control.
 * assumes an apb master on ref_clk and a timer input pin that is
 * already synchronous to ref_clk.
 */
// Chosen here: the address map and the APB slave port.
// Notes on behaviour
// - unit reset bit at 1 holds the timer array in reset; interrupt mask, request and priority bytes keep their values
// - clock gate bit at 0 stops every clock to the timer array
// - prescaler code n (4 bits for clocks 0 and 1, 2 bits for clocks 2 and 3) divides system clock by two to the n
// - writing 1 to a stop position clears that run bit; 0 does nothing
// - channel 3 mask bit at 1 blocks its count-end interrupt
// - channel 3 request flag reads 0 until a count-end request, or a start request in mode 0001, occurs
// - two priority bits form channel 3 priority level 0 to 3
// - two-bit clock select picks the channel master clock, 00 is clock 0
// - count source bit 0 counts master clock, not input pin edges
// - width bit 0 gives 16-bit counting, 1 gives 8-bit counting
// - trigger field 000 accepts only software start
// - edge field picks valid input pin edge, 00 is falling
// - mode 000x is interval mode, counting down
// - output mode bit 0 is master output, 1 is slave output (here 1 only stops the count-end toggle of the output bit)
// - output level bit 0 is active high, 1 inverts the output
// - output value bit sets the output level directly
// - output gate bit 0 stops counting from toggling the output
`timescale 1ns/1ps
`default_nettype none
`include "tai_defs.vh"

module tai_timer_array (
  input wire ref_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire ch3_timer_input_pin,
  output reg ch3_timer_output,
  output reg ch3_count_end_irq,
  output reg [1:0] ch3_irq_priority,
  output reg ch3_count_event
);

  // true when the low code bits of the free counter are all ones
  function tick_at;
    input [15:0] cnt;
    input [3:0] code;
    reg [15:0] m;
    begin
      m = (16'h0001 << code) - 16'h0001;
      tick_at = ((cnt & m) == m);
    end
  endfunction

  // true for an offset that the map holds
  function addr_hit;
    input [7:0] a;
    begin
      addr_hit = (a[1:0] == 2'h0) && (a <= `TAI_A_CH3_COUNT);
    end
  endfunction

  reg unit_rst;
  reg clk_gate;
  reg [15:0] prescale;
  reg [3:0] run_en;
  reg [7:0] irq_mask;
  reg [7:0] irq_req;
  reg [7:0] prio_low;
  reg [7:0] prio_high;
  reg [15:0] ch3_mode;
  reg [15:0] ch3_data;
  reg [7:0] out_mode;
  reg [7:0] out_pol;
  reg [7:0] out_val;
  reg [7:0] out_gate;
  reg [15:0] ch3_count;
  reg [15:0] div_cnt;
  reg pin_prev;
  reg [31:0] next_prdata;

  // apb answers in the access phase with no wait
  assign pready = 1'b1;

  // unit runs only when clocked and out of reset
  wire unit_on = clk_gate & ~unit_rst;
  wire wr = psel & penable & pwrite;
  wire uwr = wr & unit_on;

  // prescaler taps of the four operating clocks
  wire ck0 = unit_on & tick_at(div_cnt, prescale[`TAI_PS0_HI:`TAI_PS0_LO]);
  wire ck1 = unit_on & tick_at(div_cnt, prescale[`TAI_PS1_HI:`TAI_PS1_LO]);
  wire ck2 = unit_on & tick_at(div_cnt, {2'b00, prescale[`TAI_PS2_HI:`TAI_PS2_LO]});
  wire ck3 = unit_on & tick_at(div_cnt, {2'b00, prescale[`TAI_PS3_HI:`TAI_PS3_LO]});

  // channel 3 mode decode
  wire [1:0] cks = ch3_mode[`TAI_M_CKS_HI:`TAI_M_CKS_LO];
  wire [1:0] cis = ch3_mode[`TAI_M_CIS_HI:`TAI_M_CIS_LO];
  wire [2:0] sts = ch3_mode[`TAI_M_STS_HI:`TAI_M_STS_LO];
  wire split = ch3_mode[`TAI_M_SPLIT];
  wire interval = (ch3_mode[`TAI_M_MD_HI:`TAI_M_MD_LO] == `TAI_MD_INTERVAL);

  // master clock select
  reg mck;
  always @* begin
    case (cks)
      `TAI_CKS_CK0: mck = ck0;
      `TAI_CKS_CK2: mck = ck2;
      `TAI_CKS_CK1: mck = ck1;
      default: mck = ck3;
    endcase
  end

  // valid input pin edge
  wire pin_rise = ch3_timer_input_pin & ~pin_prev;
  wire pin_fall = ~ch3_timer_input_pin & pin_prev;
  reg pin_edge;
  always @* begin
    case (cis)
      `TAI_CIS_FALL: pin_edge = pin_fall;
      `TAI_CIS_RISE: pin_edge = pin_rise;
      default: pin_edge = pin_rise | pin_fall;
    endcase
  end

  // count clock: master clock or pin edges
  wire tcl = ch3_mode[`TAI_M_CCS] ? (pin_edge & unit_on) : mck;
  wire ch3_run = run_en[`TAI_CH3] & interval;
  wire cnt_tick = ch3_run & tcl;
  wire cnt_zero = split ? (ch3_count[7:0] == 8'h00) : (ch3_count == 16'h0000);
  wire cnt_end = cnt_tick & cnt_zero;

  // software start of channel 3; other trigger sources are not wired
  wire sw_start = uwr & (paddr == `TAI_A_START) & pwdata[`TAI_CH3] & (sts == 3'h0);
  wire start_irq = sw_start & interval & ch3_mode[`TAI_M_MD0];
  wire irq_set = cnt_end | start_irq;

  // reload value, low byte only in 8-bit operation
  wire [15:0] reload = split ? {ch3_count[15:8], ch3_data[7:0]} : ch3_data;

  // toggle of the output bit from counting
  wire out_toggle = cnt_end & out_gate[`TAI_CH3] & ~out_mode[`TAI_CH3];

  // software writes to output value only where the gate is off
  wire [7:0] out_wr_val = (out_val & out_gate) | (pwdata[7:0] & ~out_gate);

  // unit reset and clock gate bits; only the system reset clears them
  always @(posedge ref_clk) begin
    if (srst) begin
      unit_rst <= 1'b0;
      clk_gate <= 1'b0;
    end else begin
      if (wr && paddr == `TAI_A_UNIT_RST) begin
        unit_rst <= pwdata[0];
      end
      if (wr && paddr == `TAI_A_CLK_GATE) begin
        clk_gate <= pwdata[0];
      end
    end
  end

  // interrupt mask and priority bytes stay alive across the unit reset
  always @(posedge ref_clk) begin
    if (srst) begin
      irq_mask <= `TAI_RST_W8;
      prio_low <= `TAI_RST_W8;
      prio_high <= `TAI_RST_W8;
    end else begin
      if (wr && paddr == `TAI_A_IRQ_MASK) begin
        irq_mask <= pwdata[7:0];
      end
      if (wr && paddr == `TAI_A_IRQ_PRIO) begin
        prio_low <= pwdata[7:0];
        prio_high <= pwdata[15:8];
      end
    end
  end

  // request byte; a hardware set beats a software write in the same cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      irq_req <= `TAI_RST_W8;
    end else begin
      if (wr && paddr == `TAI_A_IRQ_REQ) begin
        irq_req <= pwdata[7:0];
      end
      if (irq_set) begin
        irq_req[`TAI_IRQ3] <= 1'b1;
      end
    end
  end

  // write strobes of the unit registers, live only while the unit runs
  wire wr_prescale = uwr & (paddr == `TAI_A_PRESCALE);
  wire wr_mode = uwr & (paddr == `TAI_A_CH3_MODE);
  wire wr_data = uwr & (paddr == `TAI_A_CH3_DATA);
  wire wr_out_mode = uwr & (paddr == `TAI_A_OUT_MODE);
  wire wr_out_pol = uwr & (paddr == `TAI_A_OUT_POL);
  wire wr_out_val = uwr & (paddr == `TAI_A_OUT_VAL);
  wire wr_out_gate = uwr & (paddr == `TAI_A_OUT_GATE);
  wire wr_start = uwr & (paddr == `TAI_A_START);
  wire wr_stop = uwr & (paddr == `TAI_A_STOP);

  // start bits; channel 3 may only run under the software trigger code
  wire [3:0] start_bits = {pwdata[`TAI_CH3] & (sts == 3'h0), pwdata[2:0]};

  // free divider and pin history; both restart from zero under unit reset
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      div_cnt <= `TAI_RST_W16;
      pin_prev <= 1'b0;
    end else if (clk_gate) begin
      div_cnt <= div_cnt + 16'h0001;
      pin_prev <= ch3_timer_input_pin;
    end
  end

  // prescaler codes of the four operating clocks
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      prescale <= `TAI_RST_W16;
    end else if (wr_prescale) begin
      prescale <= pwdata[15:0];
    end
  end

  // channel 3 mode word
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      ch3_mode <= `TAI_RST_W16;
    end else if (wr_mode) begin
      ch3_mode <= pwdata[15:0];
    end
  end

  // channel 3 compare and reload data
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      ch3_data <= `TAI_RST_W16;
    end else if (wr_data) begin
      ch3_data <= pwdata[15:0];
    end
  end

  // output mode byte
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      out_mode <= `TAI_RST_W8;
    end else if (wr_out_mode) begin
      out_mode <= pwdata[7:0];
    end
  end

  // output polarity byte
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      out_pol <= `TAI_RST_W8;
    end else if (wr_out_pol) begin
      out_pol <= pwdata[7:0];
    end
  end

  // output gate byte
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      out_gate <= `TAI_RST_W8;
    end else if (wr_out_gate) begin
      out_gate <= pwdata[7:0];
    end
  end

  // output bits: software value where ungated, then the counting toggle
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      out_val <= `TAI_RST_W8;
    end else begin
      if (wr_out_val) begin
        out_val <= out_wr_val;
      end
      if (out_toggle) begin
        out_val[`TAI_CH3] <= ~out_val[`TAI_CH3];
      end
    end
  end

  // start sets run bits, stop clears them
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      run_en <= 4'h0;
    end else begin
      if (wr_start) begin
        run_en <= run_en | start_bits;
      end
      if (wr_stop) begin
        run_en <= run_en & ~pwdata[3:0];
      end
    end
  end

  // channel 3 counter: load on start, count down, reload at zero
  always @(posedge ref_clk) begin
    if (srst || unit_rst) begin
      ch3_count <= `TAI_RST_W16;
    end else if (sw_start && interval) begin
      ch3_count <= reload;
    end else if (cnt_end) begin
      ch3_count <= reload;
    end else if (cnt_tick && split) begin
      ch3_count <= {ch3_count[15:8], ch3_count[7:0] - 8'h01};
    end else if (cnt_tick) begin
      ch3_count <= ch3_count - 16'h0001;
    end
  end

  // pin and interrupt outputs
  always @(posedge ref_clk) begin
    if (srst) begin
      ch3_timer_output <= 1'b0;
      ch3_count_end_irq <= 1'b0;
      ch3_irq_priority <= 2'h0;
      ch3_count_event <= 1'b0;
    end else begin
      ch3_timer_output <= out_val[`TAI_CH3] ^ out_pol[`TAI_CH3];
      ch3_count_end_irq <= irq_req[`TAI_IRQ3] & ~irq_mask[`TAI_IRQ3];
      ch3_irq_priority <= {prio_high[`TAI_IRQ3], prio_low[`TAI_IRQ3]};
      ch3_count_event <= cnt_end;
    end
  end

  // read mux; gated unit reads as zero
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `TAI_A_UNIT_RST: next_prdata[0] = unit_rst;
      `TAI_A_CLK_GATE: next_prdata[0] = clk_gate;
      `TAI_A_PRESCALE: next_prdata[15:0] = unit_on ? prescale : 16'h0000;
      `TAI_A_RUN: next_prdata[3:0] = unit_on ? run_en : 4'h0;
      `TAI_A_IRQ_MASK: next_prdata[7:0] = irq_mask;
      `TAI_A_IRQ_REQ: next_prdata[7:0] = irq_req;
      `TAI_A_IRQ_PRIO: next_prdata[15:0] = {prio_high, prio_low};
      `TAI_A_CH3_MODE: next_prdata[15:0] = unit_on ? ch3_mode : 16'h0000;
      `TAI_A_CH3_DATA: next_prdata[15:0] = unit_on ? ch3_data : 16'h0000;
      `TAI_A_OUT_MODE: next_prdata[7:0] = unit_on ? out_mode : 8'h00;
      `TAI_A_OUT_POL: next_prdata[7:0] = unit_on ? out_pol : 8'h00;
      `TAI_A_OUT_VAL: next_prdata[7:0] = unit_on ? out_val : 8'h00;
      `TAI_A_OUT_GATE: next_prdata[7:0] = unit_on ? out_gate : 8'h00;
      `TAI_A_CH3_COUNT: next_prdata[15:0] = unit_on ? ch3_count : 16'h0000;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // read data and error captured in the setup cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= ~addr_hit(paddr);
    end
  end

endmodule
`default_nettype wire

/* tb/tai_timer_props.sv */
/* port checker of tai_timer_array
   bound from the bench; one clock ref_clk, srst synchronous active high */
`timescale 1ns/1ps
`default_nettype none
`include "tai_defs.vh"
module tai_timer_props (
  input wire ref_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ch3_timer_input_pin,
  input wire ch3_timer_output,
  input wire ch3_count_end_irq,
  input wire [1:0] ch3_irq_priority,
  input wire ch3_count_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // write taken at this edge, priority bits it carries
  wire wr_acc = psel && penable && pwrite;
  wire [1:0] prio_wd = {pwdata[13], pwdata[5]};
  // channel 3 stop trigger, then eight cycles with no count-end pulse
  sequence s_stop3;
    wr_acc && paddr == `TAI_A_STOP && pwdata[`TAI_CH3];
  endsequence
  sequence s_quiet;
    !ch3_count_event [*8];
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_decode: assert property (psel && !penable |=> pslverr == ($past(paddr) > 8'h3c ||
    ($past(paddr) & 8'h03) != 8'h00)) else $error("pslverr wrong");
  chk_reset_clear: assert property ($fell(srst) |-> !ch3_count_event && !ch3_count_end_irq &&
    !ch3_timer_output && ch3_irq_priority == 2'h0) else $error("outputs not clear");
  chk_event_pulse: assert property (ch3_count_event |=> !ch3_count_event) else $error("long pulse");
  chk_stop_quiet: assert property (s_stop3 |-> ##3 s_quiet) else $error("event after stop");
  chk_prio_follow: assert property (wr_acc && paddr == `TAI_A_IRQ_PRIO |-> ##2
    ch3_irq_priority == $past(prio_wd, 2)) else $error("priority wrong");
  chk_irq_rise: assert property ($rose(ch3_count_end_irq) |->
    $past(ch3_count_event) || $past(wr_acc, 2)) else $error("irq without cause");
  chk_irq_fall: assert property ($fell(ch3_count_end_irq) |->
    $past(wr_acc, 2) || $past(srst)) else $error("irq dropped alone");
endmodule
`default_nettype wire

/* tb/tai_timer_array_tb.sv */
/* self-checking bench of tai_timer_array over apb
   expects tai_defs.vh on the include path; checker bound at the foot */
`timescale 1ns/1ps
`default_nettype none
`include "tai_defs.vh"
module tai_timer_array_tb;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} tai_row;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ch3_timer_input_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd, rd1;
  logic er, o;
  wire [31:0] prdata;
  wire [1:0] ch3_irq_priority;
  wire pready, pslverr, ch3_timer_output, ch3_count_end_irq, ch3_count_event;
  int err_total = 0;
  int cmp_count = 0;
  int ev_n = 0;
  int n;
  tai_row rows [11];
  tai_timer_array i_tai_timer_array (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ch3_timer_input_pin, .ch3_timer_output, .ch3_count_end_irq,
    .ch3_irq_priority, .ch3_count_event);
  // 125 MHz clock, count-end pulses counted on the falling edge
  initial forever #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (ch3_count_event === 1'b1) ev_n++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // cycles between two count-end pulses
  task gap;
    n = 0;
    @(negedge ref_clk);
    while (ch3_count_event !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    n = 1;
    while (ch3_count_event !== 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // wait for the next count-end pulse, then one more cycle for the output pin
  task nxt;
    @(negedge ref_clk);
    while (ch3_count_event !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
  // setup rows in software order, then the awkward cases
  initial begin
    rows = '{
      '{`TAI_A_PRESCALE, 32'h1, 32'h1},
      '{`TAI_A_STOP, 32'ha0f, 32'h0},
      '{`TAI_A_IRQ_MASK, 32'h20, 32'h20},
      '{`TAI_A_IRQ_REQ, 32'h0, 32'h0},
      '{`TAI_A_IRQ_PRIO, 32'h2000, 32'h2000},
      '{`TAI_A_CH3_MODE, 32'h0, 32'h0},
      '{`TAI_A_CH3_DATA, 32'hea5f, 32'hea5f},
      '{`TAI_A_OUT_MODE, 32'h0, 32'h0},
      '{`TAI_A_OUT_POL, 32'h8, 32'h8},
      '{`TAI_A_OUT_GATE, 32'h0, 32'h0},
      '{8'h40, 32'hff, 32'h0}};
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    wr(`TAI_A_UNIT_RST, 32'h1);
    wr(`TAI_A_UNIT_RST, 32'h0);
    wr(`TAI_A_CLK_GATE, 32'h1);
    foreach (rows[i]) begin
      rchk(rows[i].a, {16'h0, `TAI_RST_W16});
      wr(rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].r);
    end
    chk({31'h0, er}, 32'h1);
    chk({30'h0, ch3_irq_priority}, 32'h2);
    chk({31'h0, ch3_timer_output}, 32'h1);
    wr(`TAI_A_OUT_POL, 32'h0);
    wr(`TAI_A_OUT_VAL, 32'h8);
    wr(`TAI_A_CH3_DATA, 32'h4);
    wr(`TAI_A_START, 32'h8);
    gap;
    gap;
    chk(n, 32'd10);
    chk({31'h0, ch3_timer_output}, 32'h1);
    rchk(`TAI_A_IRQ_REQ, 32'h20);
    chk({31'h0, ch3_count_end_irq}, 32'h0);
    wr(`TAI_A_IRQ_MASK, 32'h0);
    repeat (2) @(negedge ref_clk);
    chk({31'h0, ch3_count_end_irq}, 32'h1);
    wr(`TAI_A_OUT_GATE, 32'h8);
    nxt;
    o = ch3_timer_output;
    nxt;
    chk({31'h0, ch3_timer_output}, {31'h0, ~o});
    wr(`TAI_A_OUT_MODE, 32'h8);
    nxt;
    o = ch3_timer_output;
    nxt;
    chk({31'h0, ch3_timer_output}, {31'h0, o});
    wr(`TAI_A_PRESCALE, 32'h3012);
    gap;
    gap;
    chk(n, 32'd20);
    wr(`TAI_A_CH3_MODE, 32'h8000);
    gap;
    gap;
    chk(n, 32'd10);
    wr(`TAI_A_CH3_MODE, 32'h4000);
    gap;
    gap;
    chk(n, 32'd5);
    wr(`TAI_A_CH3_MODE, 32'hc000);
    gap;
    gap;
    chk(n, 32'd40);
    wr(`TAI_A_STOP, 32'h0);
    rchk(`TAI_A_RUN, 32'h8);
    wr(`TAI_A_STOP, 32'h8);
    rchk(`TAI_A_RUN, 32'h0);
    apb(1'b0, `TAI_A_CH3_COUNT, 32'h0);
    rd1 = rd;
    repeat (20) @(posedge ref_clk);
    rchk(`TAI_A_CH3_COUNT, rd1);
    wr(`TAI_A_CH3_DATA, 32'h1);
    // falling, rising, then both edges of eight pulses
    for (int k = 0; k < 3; k++) begin
      wr(`TAI_A_CH3_MODE, 32'h1000 | (k << 6));
      ev_n = 0;
      wr(`TAI_A_START, 32'h8);
      repeat (8) begin
        @(posedge ref_clk) ch3_timer_input_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ch3_timer_input_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      chk(ev_n, (k == 2) ? 32'd8 : 32'd4);
    end
    wr(`TAI_A_STOP, 32'h8);
    wr(`TAI_A_CH3_MODE, 32'h100);
    wr(`TAI_A_START, 32'h8);
    rchk(`TAI_A_RUN, 32'h0);
    wr(`TAI_A_CH3_MODE, 32'h800);
    wr(`TAI_A_CH3_DATA, 32'h104);
    wr(`TAI_A_START, 32'h8);
    gap;
    gap;
    chk(n, 32'd20);
    wr(`TAI_A_UNIT_RST, 32'h1);
    rchk(`TAI_A_CH3_DATA, 32'h0);
    wr(`TAI_A_UNIT_RST, 32'h0);
    rchk(`TAI_A_CH3_DATA, 32'h0);
    wr(`TAI_A_CLK_GATE, 32'h0);
    wr(`TAI_A_CH3_DATA, 32'h7);
    wr(`TAI_A_CLK_GATE, 32'h1);
    rchk(`TAI_A_CH3_DATA, 32'h0);
    @(posedge ref_clk) srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rchk(`TAI_A_IRQ_REQ, 32'h0);
    end_of_test;
  end
endmodule
bind tai_timer_array tai_timer_props i_tai_timer_props (.ref_clk, .srst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .ch3_timer_input_pin, .ch3_timer_output,
  .ch3_count_end_irq, .ch3_irq_priority, .ch3_count_event);
`default_nettype wire
